// File: hdl/pmc_defines.svh
// Functional notes
// - four power modes ranked active, alternate active, sleep, hibernate
// - mode after reset is active
// - in active, active template bits enable resources; writable anytime
// - disabled resource gets clock gated and analog bias off
// - cpu may disable itself; next wakeup re-enables it
// - any wakeup returns mode to active and enables cpu
// - separate active and alternate templates, one bit per subsystem
// - alternate active applies the alternate template
// - sleep forces most resources off regardless of templates
// - sleep keeps sleep timer and rtc on low-speed or crystal osc
// - sleep wakes on comparator, pin irq, i2c, rtc, timewheel, low voltage
// - sleep runs digital and analog regulators buzzed
// - hibernate stops all clocks, retains state, wakes only on pin irq
// - hibernate disables all regulators but the hibernate one
// - core regulators enabled at power up; firmware may disable
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_ADDR_W 4
`define PMC_REG_MODE 4'h0
`define PMC_REG_ACT_TPL 4'h4
`define PMC_REG_ALT_TPL 4'h8
`define PMC_REG_REGCTL 4'hC
`define PMC_NSUB 8
`define PMC_CPU_BIT 0
`define PMC_TPL_RST 8'hFF
`define PMC_REGCTL_RST 2'b11
`define PMC_SLEEP_KEEP 8'h00
`define PMC_WK_CMP 0
`define PMC_WK_PIN 1
`define PMC_WK_I2C 2
`define PMC_WK_RTC 3
`define PMC_WK_TW 4
`define PMC_WK_LVD 5
`define PMC_NWK 6
`define PMC_SLEEP_WK_MASK 6'h3F
`define PMC_HIB_WK_MASK 6'h02
`endif

// File: hdl/pmc_pkg.sv
package pmc_pkg;
  // one-hot modes, ranked by decreasing consumption
  typedef enum logic [3:0] {
    MODE_ACTIVE = 4'b0001,
    MODE_ALT = 4'b0010,
    MODE_SLEEP = 4'b0100,
    MODE_HIB = 4'b1000
  } pmode_t;
  typedef logic [1:0] mode_code_t;
endpackage : pmc_pkg

// File: hdl/pmc_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
module pmc_gate
  import pmc_pkg::*;
#(
  parameter int NSUB = `PMC_NSUB
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // enable per subsystem
  input wire logic [NSUB-1:0] en_i,
  // gated outputs
  output logic [NSUB-1:0] clk_en_o,
  output logic [NSUB-1:0] bias_en_o
);
  genvar g;
  generate
    for (g = 0; g < NSUB; g++) begin : g_sub
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          clk_en_o[g] <= 1'b1;
          bias_en_o[g] <= 1'b1;
        end else begin
          clk_en_o[g] <= en_i[g];
          bias_en_o[g] <= en_i[g];
        end
      end
    end
  endgenerate
endmodule : pmc_gate
`default_nettype wire

// File: hdl/power_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
module power_mode_controller
  import pmc_pkg::*;
#(
  parameter int NSUB = `PMC_NSUB
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`PMC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // wakeup sources, bit order per defines
  input wire logic [`PMC_NWK-1:0] wake_i,
  // cpu self disable request
  input wire logic cpu_sleep_i,
  // subsystem gating
  output logic [NSUB-1:0] sub_clk_en_o,
  output logic [NSUB-1:0] sub_bias_en_o,
  // mode and power status
  output logic [3:0] mode_o,
  output logic lowspeed_clk_en_o,
  output logic all_clk_stop_o,
  output logic dig_reg_en_o,
  output logic ana_reg_en_o,
  output logic reg_buzz_o,
  output logic hib_reg_en_o,
  output logic retain_o
);
  pmode_t mode_q, mode_d;
  logic [NSUB-1:0] act_tpl_q, alt_tpl_q;
  logic [1:0] regctl_q;
  logic cpu_off_q;
  logic ack_q;
  logic [31:0] rdat_q;

  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire sel_mode = wb_adr_i == `PMC_REG_MODE;
  wire sel_act = wb_adr_i == `PMC_REG_ACT_TPL;
  wire sel_alt = wb_adr_i == `PMC_REG_ALT_TPL;
  wire sel_reg = wb_adr_i == `PMC_REG_REGCTL;

  function automatic pmode_t dec_mode(input mode_code_t c);
    case (c)
      2'd1: dec_mode = MODE_ALT;
      2'd2: dec_mode = MODE_SLEEP;
      2'd3: dec_mode = MODE_HIB;
      default: dec_mode = MODE_ACTIVE;
    endcase
  endfunction : dec_mode

  function automatic mode_code_t enc_mode(input pmode_t m);
    case (m)
      MODE_ALT: enc_mode = 2'd1;
      MODE_SLEEP: enc_mode = 2'd2;
      MODE_HIB: enc_mode = 2'd3;
      default: enc_mode = 2'd0;
    endcase
  endfunction : enc_mode

  // only enabled sources count: hibernate listens to pin interrupts alone
  wire [`PMC_NWK-1:0] wk_mask = (mode_q == MODE_HIB) ? `PMC_HIB_WK_MASK : `PMC_SLEEP_WK_MASK;
  wire wake = |(wake_i & wk_mask);

  // wakeup beats a same-cycle mode write so no event is lost
  always_comb begin
    mode_d = mode_q;
    if (wake) begin
      mode_d = MODE_ACTIVE;
    end else if (wr & sel_mode) begin
      mode_d = dec_mode(wb_dat_i[1:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_ACTIVE;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_off_q <= 1'b0;
    end else if (wake) begin
      cpu_off_q <= 1'b0;
    end else if (cpu_sleep_i) begin
      cpu_off_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_tpl_q <= NSUB'(`PMC_TPL_RST);
      alt_tpl_q <= NSUB'(`PMC_TPL_RST);
      regctl_q <= `PMC_REGCTL_RST;
    end else begin
      if (wr & sel_act) begin
        act_tpl_q <= wb_dat_i[NSUB-1:0];
      end
      if (wr & sel_alt) begin
        alt_tpl_q <= wb_dat_i[NSUB-1:0];
      end
      if (wr & sel_reg) begin
        regctl_q <= wb_dat_i[1:0];
      end
    end
  end

  wire [31:0] rd_mux = sel_mode ? {28'h0000_000, cpu_off_q, 1'b0, enc_mode(mode_q)} :
                       sel_act ? 32'(act_tpl_q) :
                       sel_alt ? 32'(alt_tpl_q) :
                       sel_reg ? {30'h0000_0000, regctl_q} : 32'h0000_0000;

  // single-wait-state slave: ack one cycle after the request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req) begin
        rdat_q <= rd_mux;
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // subsystem enables by mode; cpu bit also forced off while its self-disable flag is set
  logic [NSUB-1:0] en;
  always_comb begin
    case (mode_q)
      MODE_ACTIVE: en = act_tpl_q;
      MODE_ALT: en = alt_tpl_q;
      MODE_SLEEP: en = NSUB'(`PMC_SLEEP_KEEP);
      MODE_HIB: en = '0;
      default: en = act_tpl_q;
    endcase
    if (cpu_off_q) begin
      en[`PMC_CPU_BIT] = 1'b0;
    end
  end

  pmc_gate #(.NSUB(NSUB)) u_gate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(en),
    .clk_en_o(sub_clk_en_o),
    .bias_en_o(sub_bias_en_o)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_o <= MODE_ACTIVE;
      lowspeed_clk_en_o <= 1'b1;
      all_clk_stop_o <= 1'b0;
      dig_reg_en_o <= 1'b1;
      ana_reg_en_o <= 1'b1;
      reg_buzz_o <= 1'b0;
      hib_reg_en_o <= 1'b1;
      retain_o <= 1'b0;
    end else begin
      mode_o <= mode_q;
      lowspeed_clk_en_o <= mode_q != MODE_HIB;
      all_clk_stop_o <= mode_q == MODE_HIB;
      dig_reg_en_o <= regctl_q[0] & (mode_q != MODE_HIB);
      ana_reg_en_o <= regctl_q[1] & (mode_q != MODE_HIB);
      reg_buzz_o <= mode_q == MODE_SLEEP;
      hib_reg_en_o <= 1'b1;
      retain_o <= mode_q == MODE_HIB;
    end
  end
endmodule : power_mode_controller
`default_nettype wire

// File: verification/pmc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
module pmc_monitor
  import pmc_pkg::*;
#(parameter int NSUB = 8) (
  // clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`PMC_ADDR_W-1:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic [`PMC_NWK-1:0] wake_i,
  // status
  input wire logic [NSUB-1:0] sub_clk_en_o,
  input wire logic [NSUB-1:0] sub_bias_en_o,
  input wire logic [3:0] mode_o,
  input wire logic lowspeed_clk_en_o,
  input wire logic all_clk_stop_o,
  input wire logic dig_reg_en_o,
  input wire logic ana_reg_en_o,
  input wire logic reg_buzz_o,
  input wire logic hib_reg_en_o,
  input wire logic retain_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic mwr = wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == `PMC_REG_MODE);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_req |=> s_ans; endproperty
  property p_onehot; $onehot(mode_o); endproperty
  property p_boot; $past(rst_i) |-> mode_o == MODE_ACTIVE && &sub_clk_en_o && dig_reg_en_o && ana_reg_en_o; endproperty
  property p_gate; sub_clk_en_o == sub_bias_en_o; endproperty
  property p_sleep; (mode_o == MODE_SLEEP) == reg_buzz_o && (!reg_buzz_o || sub_clk_en_o == '0); endproperty
  property p_hib; mode_o == MODE_HIB |-> all_clk_stop_o && retain_o && hib_reg_en_o && !dig_reg_en_o
    && !ana_reg_en_o && !lowspeed_clk_en_o && sub_clk_en_o == '0; endproperty
  property p_wake; wake_i[`PMC_WK_PIN] |-> ##[1:2] mode_o == MODE_ACTIVE; endproperty
  property p_entry; $changed(mode_o) && mode_o != MODE_ACTIVE |-> $past(mwr, 1) || $past(mwr, 2); endproperty
  a_ack: assert property (p_ack) else $error("bus answer late or long");
  a_onehot: assert property (p_onehot) else $error("mode not one of four");
  a_boot: assert property (p_boot) else $error("wrong state after reset");
  a_gate: assert property (p_gate) else $error("clock and bias gating differ");
  a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
  a_hib: assert property (p_hib) else $error("hibernate outputs wrong");
  a_wake: assert property (p_wake) else $error("pin wakeup missed");
  a_entry: assert property (p_entry) else $error("low mode without write");
endmodule : pmc_monitor
bind power_mode_controller pmc_monitor #(.NSUB(NSUB)) u_mon (.*);
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
module testbench;
  import pmc_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, cpu_sleep_i = 0;
  logic [3:0] wb_adr_i = 0, wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, exp_q[$];
  logic [5:0] wake_i = 0;
  logic [7:0] sub_clk_en_o, sub_bias_en_o, r;
  logic [3:0] mode_o;
  logic wb_ack_o, lowspeed_clk_en_o, all_clk_stop_o, dig_reg_en_o, ana_reg_en_o, reg_buzz_o, hib_reg_en_o, retain_o;
  int n_errors = 0, n_compared = 0;
  initial forever #25 clk_i = ~clk_i;
  power_mode_controller dut (.*);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    // no local limit: a slave that never answers is caught by the watchdog
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(0, a, 0);
  endtask : rd
  // read data is judged where the answer appears, not where it was asked for
  always @(posedge clk_i) if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk("rdata", wb_dat_o, exp_q.pop_front());
  task automatic md(input logic [1:0] m);
    bus(1, `PMC_REG_MODE, 32'(m));
    repeat (2) @(posedge clk_i);
  endtask : md
  task automatic wk(input int b);
    @(posedge clk_i);
    wake_i <= 6'(1 << b);
    @(posedge clk_i);
    wake_i <= '0;
    repeat (3) @(posedge clk_i);
  endtask : wk
  task automatic st(input logic [3:0] m, input logic [7:0] s);
    chk("mode", 32'(mode_o), 32'(m));
    chk("sub", 32'(sub_clk_en_o), 32'(s));
  endtask : st
  task automatic test_done;
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    #(50 * 5000);
    n_errors++;
    test_done;
  end
  initial begin
    void'($urandom(81));
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    rd(`PMC_REG_MODE, 0);
    rd(`PMC_REG_ACT_TPL, 32'h0000_00FF);
    rd(`PMC_REG_ALT_TPL, 32'h0000_00FF);
    rd(`PMC_REG_REGCTL, 32'h0000_0003);
    rd(4'h2, 0);
    r = 8'($urandom) | 8'h01;
    bus(1, `PMC_REG_ACT_TPL, 32'(r));
    repeat (2) @(posedge clk_i);
    st(MODE_ACTIVE, r);
    @(posedge clk_i);
    cpu_sleep_i <= 1;
    @(posedge clk_i);
    cpu_sleep_i <= 0;
    repeat (2) @(posedge clk_i);
    st(MODE_ACTIVE, r & 8'hFE);
    wk(0);
    st(MODE_ACTIVE, r);
    bus(1, `PMC_REG_ALT_TPL, 32'h0000_00A6);
    md(1);
    st(MODE_ALT, 8'hA6);
    wk($urandom_range(5));
    st(MODE_ACTIVE, r);
    for (int b = 0; b < 6; b++) begin
      md(2);
      chk("buzz", 32'(reg_buzz_o), 1);
      chk("lowspeed", 32'(lowspeed_clk_en_o), 1);
      st(MODE_SLEEP, 0);
      wk(b);
      st(MODE_ACTIVE, r);
    end
    md(3);
    chk("hib", {all_clk_stop_o, retain_o, hib_reg_en_o, dig_reg_en_o, ana_reg_en_o}, 5'h1C);
    chk("lowspeed", 32'(lowspeed_clk_en_o), 0);
    wk(0);
    st(MODE_HIB, 0);
    wk(1);
    st(MODE_ACTIVE, r);
    bus(1, `PMC_REG_REGCTL, 0);
    repeat (2) @(posedge clk_i);
    chk("regs", {dig_reg_en_o, ana_reg_en_o}, 0);
    test_done;
  end
endmodule : testbench
`default_nettype wire
